/* hw/ocs_pkg.sv */
// ocs_pkg: register map, field layouts, reset values and timing for the
// offset calibration scheduler.
// assumes a 200 MHz aclk and an AXI4-Lite register bus with 32-bit data.
package ocs_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned ADDR_W = 8;
	// time figures in their own units
	localparam int unsigned FULL_CAL_S = 20;
	localparam int unsigned FIRST_IDLE_S = 20;
	localparam int unsigned IDLE_S = 5;
	localparam int unsigned SHORT_CAL_S = 16;
	localparam int unsigned DRIFT_HOLD_S = 60;
	localparam int unsigned SLEEP_GAP_H = 10;
	localparam int unsigned CKSUM_MS = 5;
	localparam int unsigned CMD_CAL_MS = 100;
	localparam int unsigned SEC_PER_H = 3600;
	// one-second tick divider
	localparam int unsigned TICK_CYC = CLK_HZ;
	localparam int unsigned CKSUM_CYC = CLK_HZ / 1000 * CKSUM_MS;
	localparam int unsigned CMD_CAL_CYC = CLK_HZ / 1000 * CMD_CAL_MS;
	localparam int unsigned SLEEP_GAP_S = SLEEP_GAP_H * SEC_PER_H;
	// thresholds in measurement units (mA, mV, 0.1 C)
	localparam logic [15:0] CUR_DRIFT_MA = 16'h0064;
	localparam logic [15:0] VOLT_DRIFT_MV = 16'h0100;
	localparam logic [15:0] VOLT_ABORT_MV = 16'h0020;
	localparam logic [15:0] TEMP_DRIFT_DC = 16'h0050;
	localparam logic [15:0] TEMP_LO_DC = 16'h0032;
	localparam logic [15:0] TEMP_HI_DC = 16'h01c2;
	// register byte addresses
	localparam logic [ADDR_W-1:0] A_ALL_CK = 8'h06 << 2;
	localparam logic [ADDR_W-1:0] A_CHEM_CK = 8'h08 << 2;
	localparam logic [ADDR_W-1:0] A_STAT_CK = 8'h0a << 2;
	localparam logic [ADDR_W-1:0] A_CTRL = 8'h40;
	localparam logic [ADDR_W-1:0] A_STATUS = 8'h44;
	localparam logic [ADDR_W-1:0] A_GAIN = 8'h48;
	localparam logic [ADDR_W-1:0] A_DELTA = 8'h4c;
	localparam logic [ADDR_W-1:0] A_OFS = 8'h50;
	localparam logic [ADDR_W-1:0] A_TOFS = 8'h54;
	localparam logic [ADDR_W-1:0] A_SLEEP_I = 8'h58;
	// control register bits
	localparam int unsigned C_CALMODE = 0;
	localparam int unsigned C_CMDCAL = 1;
	localparam int unsigned C_CKSUM = 2;
	// reset values
	localparam logic [15:0] CK_MASK = 16'h7fff;
	localparam logic [15:0] CHEM_CK_RST = 16'h7c23;
	localparam logic [15:0] ALL_CK_RST = 16'h0000;
	localparam logic [15:0] STAT_CK_RST = 16'h0000;
	// 0.9536 and 1119000 as IEEE single precision
	localparam logic [31:0] GAIN_RST = 32'h3f74_1f21;
	localparam logic [31:0] DELTA_RST = 32'h4988_98c0;
	localparam logic [15:0] CC_OFS_RST = 16'h0598;
	localparam logic [7:0] BOARD_OFS_RST = 8'h58;
	localparam logic [15:0] SLEEP_I_RST = 16'h000a;
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;

	typedef enum {OCS_IDLE, OCS_CAL, OCS_CKSUM} ocs_state_e;

	typedef struct packed {
		logic [15:0] cc_ofs;
		logic [7:0] board_ofs;
		logic [7:0] int_t_ofs;
		logic [7:0] ext_t_ofs;
		logic [7:0] pack_v_ofs;
	} ocs_ofs_s;

	typedef struct packed {
		logic [15:0] avg_cur;
		logic [15:0] volt;
		logic [15:0] temp;
	} ocs_meas_s;

	function automatic logic [15:0] ocs_absdiff(input logic [15:0] a,
		input logic [15:0] b);
		return ($signed(a) > $signed(b)) ? a - b : b - a;
	endfunction
endpackage

/* hw/ocs_axil.sv */
// ocs_axil: AXI4-Lite slave front end, one write and one read at a time.
// assumes the parent decodes addresses and supplies read data in one cycle.
`timescale 1ns/10ps
`default_nettype none
module ocs_axil
	import ocs_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [ADDR_W-1:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic stall,
	output logic wr_en,
	output logic [ADDR_W-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic [ADDR_W-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);
	logic aw_have_q, w_have_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	wire logic do_wr = aw_have_q && w_have_q && !s_bvalid && !stall;
	wire logic do_rd = s_arvalid && !s_rvalid && !stall;

	assign s_awready = !aw_have_q && !stall;
	assign s_wready = !w_have_q && !stall;
	assign s_arready = do_rd;
	assign wr_en = do_wr;
	assign wr_addr = awaddr_q;
	assign wr_data = wdata_q;
	assign wr_strb = wstrb_q;
	assign rd_addr = s_araddr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			s_bvalid <= 1'b0;
			s_bresp <= RESP_OK;
			s_rvalid <= 1'b0;
			s_rdata <= '0;
			s_rresp <= RESP_OK;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_have_q <= 1'b1;
				wdata_q <= s_wdata;
				wstrb_q <= s_wstrb;
			end
			if (do_wr) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= wr_ok ? RESP_OK : RESP_ERR;
			end else if (s_bready) begin
				s_bvalid <= 1'b0;
			end
			if (do_rd) begin
				s_rvalid <= 1'b1;
				s_rdata <= rd_ok ? rd_data : '0;
				s_rresp <= rd_ok ? RESP_OK : RESP_ERR;
			end else if (s_rready) begin
				s_rvalid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* hw/ocs_top.sv */
// ocs_top: offset calibration scheduler of a charge-integrating gauge.
// assumes measurements synchronous to aclk, updated by the measuring core.
// Operation
// - static config checksum skips counters, lot codes, lifetime, state, calibration
// - chemistry checksum also covers low-rate resistance table and invalid-charge limits
// - checksum words held in 0..0x7FFF; chemistry resets 0x7C23, others zero
// - calibration parameters change only by commands in calibration mode; cc_ofs is also loaded at the end of every calibration not aborted
// - current uses time-free gain, capacity uses time-based delta factor
// - five separate offset parameters: converter, board, int temp, ext temp, pack V
// - sense inputs shorted together while any converter offset calibration runs
// - full calibration integrates about 20 s; commanded one is short, temporary
// - first accurate calibration when both bus lines stay low over 20 s
// - lines low over 5 s and current under sleep threshold: 16 s calibration
// - sleep entry starts calibration unless temp outside 5..45 C; max once/10 h
// - calibrate when current at most 100 mA and drift held 60 s
// - during calibration keep integrating at last measured rate
// - abort calibration if voltage falls more than 32 mV during it
// - measured offset subtracted from every later sense voltage reading
// - temperature gets additive offset only, one per sensor
// - checksum is 16-bit byte sum with top bit cleared
// - bus is silent during a checksum run of about 5 ms
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none
module ocs_top
	import ocs_pkg::*;
#(
	parameter int unsigned TICK = TICK_CYC,
	parameter int unsigned CKSUM_T = CKSUM_CYC,
	parameter int unsigned CMD_CAL_T = CMD_CAL_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [ADDR_W-1:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic bus_clk_line,
	input wire logic bus_data_line,
	input wire logic sleep_entry,
	input wire ocs_meas_s meas,
	input wire logic [15:0] sense_voltage,
	input wire logic ext_sensor_sel,
	input wire logic [15:0] raw_temp,
	input wire logic [15:0] cksum_byte_sum,
	input wire logic cal_sample_valid,
	input wire logic [15:0] cal_sample,
	output logic sense_short,
	output logic cal_busy,
	output logic hold_rate,
	output logic [15:0] sense_corrected,
	output logic [15:0] temp_corrected,
	output logic [31:0] current_gain_factor,
	output logic [31:0] capacity_gain_factor
);
	ocs_state_e st_q, st_d;
	logic [31:0] tick_cnt_q, sec_q, idle_s_q, drift_s_q, gap_s_q, cnt_q;
	logic first_done_q, gap_armed_q, cal_mode_q, cmd_cal_q;
	logic [15:0] all_ck_q, chem_ck_q, stat_ck_q, sleep_i_q;
	logic [15:0] v_ref_q, t_ref_q, v_start_q;
	ocs_ofs_s ofs_q;
	logic [31:0] acc_q;
	wire logic tick = (tick_cnt_q == TICK - 1);
	wire logic bus_idle = !bus_clk_line && !bus_data_line;
	wire logic cal_run = (st_q == OCS_CAL);

	////////////////////////////////////////////////////////////////////////
	// register bus
	logic wr_en, wr_ok, rd_ok;
	logic [ADDR_W-1:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	ocs_axil u_axil (
		.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready),
		.stall(st_q == OCS_CKSUM),
		.wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_strb(wr_strb), .wr_ok(wr_ok), .rd_addr(rd_addr),
		.rd_data(rd_data), .rd_ok(rd_ok)
	);

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] r);
		return a == r;
	endfunction

	wire logic cal_reg = hit(wr_addr, A_GAIN) || hit(wr_addr, A_DELTA) ||
		hit(wr_addr, A_OFS) || hit(wr_addr, A_TOFS);
	wire logic wr_known = cal_reg || hit(wr_addr, A_ALL_CK) ||
		hit(wr_addr, A_CHEM_CK) || hit(wr_addr, A_STAT_CK) ||
		hit(wr_addr, A_CTRL) || hit(wr_addr, A_SLEEP_I) ||
		hit(wr_addr, A_STATUS);
	assign wr_ok = wr_known && (!cal_reg || cal_mode_q);
	wire logic cal_wr = wr_en && cal_mode_q;
	wire logic [15:0] wr_ck = wr_data[15:0] & CK_MASK;

	always_comb begin
		rd_ok = 1'b1;
		rd_data = '0;
		case (rd_addr)
			A_ALL_CK: rd_data = {16'h0000, all_ck_q};
			A_CHEM_CK: rd_data = {16'h0000, chem_ck_q};
			A_STAT_CK: rd_data = {16'h0000, stat_ck_q};
			A_CTRL: rd_data = {29'h0000_0000, 1'b0, cmd_cal_q, cal_mode_q};
			A_STATUS: rd_data = {28'h000_0000, first_done_q, gap_armed_q,
				st_q == OCS_CKSUM, cal_run};
			A_GAIN: rd_data = current_gain_factor;
			A_DELTA: rd_data = capacity_gain_factor;
			A_OFS: rd_data = {ofs_q.cc_ofs, ofs_q.board_ofs, ofs_q.pack_v_ofs};
			A_TOFS: rd_data = {16'h0000, ofs_q.int_t_ofs, ofs_q.ext_t_ofs};
			A_SLEEP_I: rd_data = {16'h0000, sleep_i_q};
			default: rd_ok = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// trigger conditions
	wire logic [15:0] v_drift = ocs_absdiff(meas.volt, v_ref_q);
	wire logic [15:0] t_drift = ocs_absdiff(meas.temp, t_ref_q);
	wire logic drifted = (v_drift >= VOLT_DRIFT_MV) ||
		(t_drift > TEMP_DRIFT_DC);
	wire logic low_cur = $signed(meas.avg_cur) <= $signed(CUR_DRIFT_MA);
	wire logic temp_ok = ($signed(meas.temp) > $signed(TEMP_LO_DC)) &&
		($signed(meas.temp) < $signed(TEMP_HI_DC));
	wire logic trig_first = !first_done_q && idle_s_q >= FIRST_IDLE_S;
	wire logic trig_idle = first_done_q && idle_s_q >= IDLE_S &&
		$signed(meas.avg_cur) < $signed(sleep_i_q);
	wire logic trig_sleep = sleep_entry && temp_ok && gap_armed_q;
	wire logic trig_drift = low_cur && drift_s_q >= DRIFT_HOLD_S;
	wire logic trig_cmd = cal_mode_q && cmd_cal_q;
	wire logic trig_any = trig_first || trig_idle || trig_sleep ||
		trig_drift || trig_cmd;
	wire logic v_abort = $signed(v_start_q) - $signed(meas.volt) >
		$signed(VOLT_ABORT_MV);
	wire logic cksum_go = wr_en && hit(wr_addr, A_CTRL) && wr_strb[0] &&
		wr_data[C_CKSUM];
	// full calibration runs longer than the idle-triggered one
	wire logic [31:0] cal_len = cmd_cal_q ? CMD_CAL_T :
		(first_done_q ? SHORT_CAL_S : FULL_CAL_S);
	wire logic cal_end = cmd_cal_q ? (cnt_q >= cal_len) :
		(sec_q >= cal_len);

	always_comb begin
		st_d = st_q;
		case (st_q)
			OCS_IDLE: begin
				if (cksum_go)
					st_d = OCS_CKSUM;
				else if (trig_any)
					st_d = OCS_CAL;
			end
			OCS_CAL: if (v_abort || cal_end) st_d = OCS_IDLE;
			OCS_CKSUM: if (cnt_q >= CKSUM_T - 1) st_d = OCS_IDLE;
			default: st_d = OCS_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// timers and sequence
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= OCS_IDLE;
			tick_cnt_q <= '0;
			sec_q <= '0;
			cnt_q <= '0;
			idle_s_q <= '0;
			drift_s_q <= '0;
			gap_s_q <= '0;
			gap_armed_q <= 1'b1;
			first_done_q <= 1'b0;
			acc_q <= '0;
			v_ref_q <= '0;
			t_ref_q <= '0;
			v_start_q <= '0;
		end else begin
			st_q <= st_d;
			tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'd1;
			cnt_q <= (st_d != st_q) ? '0 : cnt_q + 32'd1;
			if (!bus_idle)
				idle_s_q <= '0;
			else if (tick && !cal_run)
				idle_s_q <= idle_s_q + 32'd1;
			if (!drifted)
				drift_s_q <= '0;
			else if (tick)
				drift_s_q <= drift_s_q + 32'd1;
			if (tick && !gap_armed_q)
				gap_s_q <= gap_s_q + 32'd1;
			if (gap_s_q >= SLEEP_GAP_S) begin
				gap_armed_q <= 1'b1;
				gap_s_q <= '0;
			end
			if (st_q == OCS_IDLE && st_d == OCS_CAL) begin
				sec_q <= '0;
				acc_q <= '0;
				v_start_q <= meas.volt;
				if (trig_sleep)
					gap_armed_q <= 1'b0;
			end else if (cal_run) begin
				if (tick)
					sec_q <= sec_q + 32'd1;
				if (cal_sample_valid)
					acc_q <= acc_q + {{16{cal_sample[15]}}, cal_sample};
			end
			if (cal_run && st_d == OCS_IDLE && !v_abort) begin
				idle_s_q <= '0;
				drift_s_q <= '0;
				v_ref_q <= meas.volt;
				t_ref_q <= meas.temp;
				if (!cmd_cal_q)
					first_done_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers and corrected outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			all_ck_q <= ALL_CK_RST;
			chem_ck_q <= CHEM_CK_RST;
			stat_ck_q <= STAT_CK_RST;
			cal_mode_q <= 1'b0;
			cmd_cal_q <= 1'b0;
			sleep_i_q <= SLEEP_I_RST;
			current_gain_factor <= GAIN_RST;
			capacity_gain_factor <= DELTA_RST;
			ofs_q <= '{CC_OFS_RST, BOARD_OFS_RST, 8'h00, 8'h00, 8'h00};
			sense_short <= 1'b0;
			cal_busy <= 1'b0;
			hold_rate <= 1'b0;
			sense_corrected <= '0;
			temp_corrected <= '0;
		end else begin
			if (st_q == OCS_CKSUM && st_d == OCS_IDLE) begin
				// covered set is chosen by the engine
				if (cksum_byte_sum[15:0] != chem_ck_q)
					stat_ck_q <= cksum_byte_sum & CK_MASK;
			end
			if (wr_en) begin
				case (wr_addr)
					A_ALL_CK: all_ck_q <= wr_ck;
					A_CHEM_CK: chem_ck_q <= wr_ck;
					A_STAT_CK: stat_ck_q <= wr_ck;
					A_CTRL: begin
						cal_mode_q <= wr_data[C_CALMODE];
						cmd_cal_q <= wr_data[C_CMDCAL] && wr_data[C_CALMODE];
					end
					A_SLEEP_I: sleep_i_q <= wr_data[15:0];
					default: ;
				endcase
			end
			if (cal_wr) begin
				case (wr_addr)
					A_GAIN: current_gain_factor <= wr_data;
					A_DELTA: capacity_gain_factor <= wr_data;
					A_OFS: begin
						ofs_q.cc_ofs <= wr_data[31:16];
						ofs_q.board_ofs <= wr_data[15:8];
						ofs_q.pack_v_ofs <= wr_data[7:0];
					end
					A_TOFS: begin
						ofs_q.int_t_ofs <= wr_data[15:8];
						ofs_q.ext_t_ofs <= wr_data[7:0];
					end
					default: ;
				endcase
			end
			if (cal_run && st_d == OCS_IDLE && !v_abort)
				ofs_q.cc_ofs <= acc_q[15:0];
			// an aborted commanded run must not restart itself
			if (cal_run && st_d == OCS_IDLE)
				cmd_cal_q <= 1'b0;
			sense_short <= (st_d == OCS_CAL);
			cal_busy <= (st_d == OCS_CAL);
			hold_rate <= (st_d == OCS_CAL);
			sense_corrected <= sense_voltage - ofs_q.cc_ofs;
			temp_corrected <= raw_temp + {{8{ext_sensor_sel ?
				ofs_q.ext_t_ofs[7] : ofs_q.int_t_ofs[7]}},
				ext_sensor_sel ? ofs_q.ext_t_ofs : ofs_q.int_t_ofs};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_short_follows;
		@(posedge aclk) disable iff (!aresetn) cal_run |-> sense_short;
	endproperty
	a_short_follows: assert property (p_short_follows)
		else $error("sense inputs not shorted during calibration");
	property p_ck_range;
		@(posedge aclk) disable iff (!aresetn)
			!all_ck_q[15] && !chem_ck_q[15] && !stat_ck_q[15];
	endproperty
	a_ck_range: assert property (p_ck_range)
		else $error("checksum word above 0x7fff");
	property p_gain_locked;
		@(posedge aclk) disable iff (!aresetn)
			!cal_mode_q |=> $stable(current_gain_factor);
	endproperty
	a_gain_locked: assert property (p_gain_locked)
		else $error("gain changed outside calibration mode");
	property p_idle_clear;
		@(posedge aclk) disable iff (!aresetn) !bus_idle |=> idle_s_q == 0;
	endproperty
	a_idle_clear: assert property (p_idle_clear)
		else $error("idle timer not cleared");
	property p_bus_silent;
		@(posedge aclk) disable iff (!aresetn)
			st_q == OCS_CKSUM |-> !s_awready && !s_arready;
	endproperty
	a_bus_silent: assert property (p_bus_silent)
		else $error("bus answered during checksum");
	property p_abort;
		@(posedge aclk) disable iff (!aresetn)
			cal_run && v_abort |=> st_q == OCS_IDLE;
	endproperty
	a_abort: assert property (p_abort)
		else $error("calibration not aborted on voltage drop");
	property p_first;
		@(posedge aclk) disable iff (!aresetn)
			st_q == OCS_IDLE && trig_first && !cksum_go |=> cal_run ##1 sense_short;
	endproperty
	a_first: assert property (p_first)
		else $error("first idle calibration not started");
	property p_sleep_gap;
		@(posedge aclk) disable iff (!aresetn)
			sleep_entry && !gap_armed_q && !trig_first && !trig_idle &&
			!trig_drift && !trig_cmd && st_q == OCS_IDLE && !cksum_go
			|=> !cal_run;
	endproperty
	a_sleep_gap: assert property (p_sleep_gap)
		else $error("sleep calibration repeated within gap");
endmodule
`default_nettype wire

/* tb/ocs_host_model.sv */
// ocs_host_model: two-wire host controller seen from the gauge's bus pins.
// assumes pulled-up lines; idle_req makes the host hold both lines low.
`timescale 1ns/10ps
`default_nettype none
module ocs_host_model
	import ocs_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic idle_req,
	output logic scl_line,
	output logic sda_line
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;

	assign cnt_d = cnt_q + 4'h1;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	// traffic: clock toggles, data changes; both low only four cycles in 16
	assign scl_line = idle_req ? 1'b0 : cnt_q[1];
	assign sda_line = idle_req ? 1'b0 : cnt_q[3];
endmodule
`default_nettype wire

/* tb/offset_calibration_scheduler_tb.sv */
// offset_calibration_scheduler_tb: self-checking bench for ocs_top.
// assumes ocs_top with a 10-cycle second and short run lengths.
`timescale 1ns/10ps
`default_nettype none
module offset_calibration_scheduler_tb
	import ocs_pkg::*;
;
	localparam int TK = 10;
	localparam int CK = 20;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
	logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
	logic s_arvalid = 1'b0, s_rready = 1'b0;
	logic [31:0] s_wdata = 32'h0000_0000;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp;
	logic [31:0] s_rdata, current_gain_factor, capacity_gain_factor;
	logic scl_line, sda_line, idle_req = 1'b0, sleep_entry = 1'b0;
	ocs_meas_s meas = '{avg_cur: 16'd50, volt: 16'd4000, temp: 16'd250};
	logic [15:0] sense_voltage = 16'h0000, raw_temp = 16'h0000;
	logic [15:0] cksum_byte_sum = 16'h0000, cal_sample = 16'h0000;
	logic ext_sensor_sel = 1'b0, cal_sample_valid = 1'b0;
	logic sense_short, cal_busy, hold_rate;
	logic [15:0] sense_corrected, temp_corrected;
	logic [33:0] rq[$], exp_r;
	logic [1:0] bq[$], exp_b;
	logic [31:0] rs = 32'hc54a_5440;
	int n_mismatch = 0, num_checks = 0, n, i;

	always #2.5 aclk = ~aclk;

	ocs_host_model u_host (.aclk(aclk), .aresetn(aresetn),
		.idle_req(idle_req), .scl_line(scl_line), .sda_line(sda_line));

	ocs_top #(.TICK(TK), .CKSUM_T(CK), .CMD_CAL_T(30)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
		.s_rvalid(s_rvalid), .s_rready(s_rready),
		.bus_clk_line(scl_line), .bus_data_line(sda_line),
		.sleep_entry(sleep_entry), .meas(meas),
		.sense_voltage(sense_voltage), .ext_sensor_sel(ext_sensor_sel),
		.raw_temp(raw_temp), .cksum_byte_sum(cksum_byte_sum),
		.cal_sample_valid(cal_sample_valid), .cal_sample(cal_sample),
		.sense_short(sense_short), .cal_busy(cal_busy),
		.hold_rate(hold_rate), .sense_corrected(sense_corrected),
		.temp_corrected(temp_corrected),
		.current_gain_factor(current_gain_factor),
		.capacity_gain_factor(capacity_gain_factor));

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		int k;
		bq.push_back(e);
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
			if (s_awvalid && s_awready) s_awvalid <= 1'b0;
			if (s_wvalid && s_wready) s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1 && k < 5000);
		s_bready <= 1'b0;
		if (k >= 5000) n_mismatch++;
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e,
		output int k);
		rq.push_back(e);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
			if (s_arvalid && s_arready) s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1 && k < 5000);
		s_rready <= 1'b0;
		if (k >= 5000) n_mismatch++;
	endtask

	// waits a bounded number of edges for sense_short to reach v
	task automatic wt(input logic v, input int lim, output int k);
		k = 0;
		while (sense_short !== v && k < lim) begin
			@(posedge aclk);
			k++;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		if (s_rvalid === 1'b1 && s_rready === 1'b1) begin
			exp_r = rq.pop_front();
			chk({s_rresp, s_rdata} === exp_r, "read data");
		end
		if (s_bvalid === 1'b1 && s_bready === 1'b1) begin
			exp_b = bq.pop_front();
			chk(s_bresp === exp_b, "write response");
		end
	end

	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		close_out();
	end

	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rd(A_CHEM_CK, {RESP_OK, 16'h0000, CHEM_CK_RST}, n);
		rd(A_ALL_CK, {RESP_OK, 32'h0000_0000}, n);
		rd(A_STAT_CK, {RESP_OK, 32'h0000_0000}, n);
		rd(A_GAIN, {RESP_OK, GAIN_RST}, n);
		rd(A_DELTA, {RESP_OK, DELTA_RST}, n);
		rd(8'hfc, {RESP_ERR, 32'h0000_0000}, n);
		wr(A_GAIN, 32'h3f80_0000, RESP_ERR);
		rd(A_GAIN, {RESP_OK, GAIN_RST}, n);
		chk(capacity_gain_factor === DELTA_RST, "delta out");
		wr(A_CHEM_CK, 32'h0000_ffff, RESP_OK);
		rd(A_CHEM_CK, {RESP_OK, 32'h0000_7fff}, n);
		$display("register test done");
		// idle bus broken by traffic, then held low
		idle_req <= 1'b1;
		repeat (150) @(posedge aclk);
		idle_req <= 1'b0;
		repeat (8) @(posedge aclk);
		idle_req <= 1'b1;
		wt(1'b1, 400, n);
		chk(n > 19 * TK && n <= 22 * TK, "first idle cal");
		chk(hold_rate === 1'b1 && cal_busy === 1'b1, "hold");
		cal_sample <= 16'h0003;
		cal_sample_valid <= 1'b1;
		@(posedge aclk);
		cal_sample_valid <= 1'b0;
		sense_voltage <= 16'd100;
		wt(1'b0, 400, n);
		chk(n >= 18 * TK, "full cal length");
		repeat (3) @(posedge aclk);
		chk(sense_corrected === 16'd97, "offset used");
		idle_req <= 1'b0;
		meas.avg_cur <= 16'd5;
		repeat (8) @(posedge aclk);
		idle_req <= 1'b1;
		wt(1'b1, 200, n);
		chk(n > 4 * TK && n <= 7 * TK, "idle cal");
		wt(1'b0, 300, n);
		chk(n >= 15 * TK && n <= 17 * TK + 2, "16 s cal");
		idle_req <= 1'b0;
		meas.avg_cur <= 16'd50;
		repeat (8) @(posedge aclk);
		idle_req <= 1'b1;
		wt(1'b1, 100, n);
		chk(sense_short === 1'b0, "no cal at high current");
		idle_req <= 1'b0;
		$display("idle test done");
		// calibration mode writes
		wr(A_CTRL, 32'h0000_0001, RESP_OK);
		rs = lfsr(rs);
		wr(A_OFS, {rs[15:0], 16'h1234}, RESP_OK);
		wr(A_TOFS, 32'h0000_05fe, RESP_OK);
		wr(A_GAIN, 32'h3f80_0000, RESP_OK);
		rd(A_OFS, {RESP_OK, rs[15:0], 16'h1234}, n);
		chk(current_gain_factor === 32'h3f80_0000, "gain");
		sense_voltage <= rs[31:16];
		raw_temp <= 16'd300;
		repeat (3) @(posedge aclk);
		chk(sense_corrected === rs[31:16] - rs[15:0], "sense");
		chk(temp_corrected === 16'd305, "internal temp");
		ext_sensor_sel <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(temp_corrected === 16'd298, "external temp");
		// commanded calibration, abort on voltage fall
		wr(A_CTRL, 32'h0000_0003, RESP_OK);
		wt(1'b1, 10, n);
		chk(sense_short === 1'b1, "commanded cal");
		meas.volt <= 16'd3968;
		repeat (5) @(posedge aclk);
		chk(cal_busy === 1'b1, "32 mV fall kept");
		meas.volt <= 16'd3959;
		wt(1'b0, 5, n);
		chk(sense_short === 1'b0, "abort");
		wr(A_CTRL, 32'h0000_0000, RESP_OK);
		$display("calibration mode test done");
		// checksum run silences the register bus
		cksum_byte_sum <= 16'habcd;
		wr(A_CTRL, 32'h0000_0004, RESP_OK);
		rd(A_CHEM_CK, {RESP_OK, 32'h0000_7fff}, n);
		chk(n >= CK - 2, "silent run");
		rd(A_STAT_CK, {RESP_OK, 32'h0000_2bcd}, n);
		$display("checksum test done");
		// sleep entry: two temperatures refused, one taken, one too soon
		for (i = 0; i < 4; i++) begin
			meas.temp <= (i == 0) ? 16'd50 : (i == 1) ? 16'd450 : 16'd250;
			@(posedge aclk);
			sleep_entry <= 1'b1;
			@(posedge aclk);
			sleep_entry <= 1'b0;
			wt(1'b1, 20, n);
			chk(sense_short === (i == 2), "sleep cal");
			wt(1'b0, 400, n);
		end
		$display("sleep test done");
		meas.temp <= 16'd340;
		wt(1'b1, 700, n);
		chk(n >= 59 * TK && n <= 62 * TK, "drift cal");
		$display("drift test done");
		close_out();
	end
endmodule
`default_nettype wire
